//--- hdl/synth_cfg_defines.vh
// Field positions, codes and reset values for the synthesizer configuration bank.
`ifndef SYNTH_CFG_DEFINES_VH
`define SYNTH_CFG_DEFINES_VH
`define WORD_W 32
`define SEL_HI 2
`define SEL_LO 0
`define SEL_FREQ 3'h0
`define SEL_PPM 3'h1
`define SEL_REFLOOP 3'h2
`define SEL_CLKDIV 3'h3
`define SEL_OUTSTG 3'h4
`define SEL_LOCKPIN 3'h5
`define NUMER_HI 14
`define NUMER_LO 3
`define WHOLE_HI 30
`define WHOLE_LO 15
`define DBUF_EN_BIT 13
`define SLEEP_BIT 5
`define OUTDIV_HI 22
`define OUTDIV_LO 20
`define LOCKSEL_HI 23
`define LOCKSEL_LO 22
`define LOCK_LOW0 2'h0
`define LOCK_DIGITAL 2'h1
`define LOCK_LOW1 2'h2
`define LOCK_HIGH 2'h3
`define WORD_RESET 32'h0000_0000
`define PPM_DBUF_MASK 32'h07FF_FFF8
`define REF_DBUF_MASK 32'h03FF_DE00
`endif

//--- hdl/synth_serial_config_regs.v
// Three-wire serial configuration register bank with staged settings and lock pin select.
//
// Notes on behaviour
// (RL1) Words shift in MSB first, one bit per rising serial clock edge.
// (RL2) Load strobe rising edge copies the word into latch chosen by low three bits.
// (RL3) Frequency word holds 12-bit numerator in bits 14..3, 16-bit whole divider above.
// (RL4) Staged fields are held until the next frequency word write applies them.
// (RL5) Output divider bits staged only when reference word bit 13 is set.
// (RL6) Lock pin: 00 low, 01 digital lock, 10 low, 11 high.
// (RL7) Host writes the frequency word after changing any staged setting.
// (RL8) Sleep keeps registers, resets lock detect, serial input stays active.
// (RL9) Host writes reserved bits as shown and programs registers five down to zero; the bench writes registers 1, 4, 3, then 0 first.
`timescale 1ns/1ns
`default_nettype none
`include "synth_cfg_defines.vh"
module synth_serial_config_regs #(
    parameter W = `WORD_W
) (
    input wire clk,
    input wire rst,
    input wire sclk,
    input wire sdata,
    input wire load_strobe,
    input wire digital_lock_in,
    output reg [W-1:0] frequency_word,
    output reg [W-1:0] prescale_phase_modulus,
    output reg [W-1:0] reference_and_loop_control,
    output reg [W-1:0] clock_divider_control,
    output reg [W-1:0] output_stage_control,
    output reg [W-1:0] lock_pin_control,
    output reg [15:0] whole_divider,
    output reg [11:0] partial_numerator,
    output reg sleep_request,
    output reg lock_pin
);
    reg [2:0] sclk_s_r;
    reg [1:0] sdata_s_r;
    reg [2:0] le_s_r;
    reg [1:0] dl_s_r;
    reg [W-1:0] shift_r;
    reg [W-1:0] stage_ppm_r;
    reg [W-1:0] stage_ref_r;
    reg [2:0] stage_div_r;
    wire sclk_rise;
    wire le_rise;
    wire [2:0] sel;
    wire dbuf_en;
    wire [W-1:0] ppm_dbuf_mask;
    wire [W-1:0] ref_dbuf_mask;
    reg [W-1:0] shift_nxt;
    reg [W-1:0] freq_nxt;
    reg [W-1:0] ppm_nxt;
    reg [W-1:0] refloop_nxt;
    reg [W-1:0] clkdiv_nxt;
    reg [W-1:0] outstg_nxt;
    reg [W-1:0] lockctl_nxt;
    reg [W-1:0] stage_ppm_nxt;
    reg [W-1:0] stage_ref_nxt;
    reg [2:0] stage_div_nxt;
    reg [15:0] whole_nxt;
    reg [11:0] numer_nxt;
    reg sleep_nxt;
    reg lock_nxt;

    // Stage 0 feeds stage 1 only; edges are found between stages 1 and 2.
    assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    assign le_rise = le_s_r[1] & ~le_s_r[2];
    assign sel = shift_r[`SEL_HI:`SEL_LO];
    assign dbuf_en = reference_and_loop_control[`DBUF_EN_BIT];
    // Only the marked fields of these two words wait for the frequency word.
    assign ppm_dbuf_mask = `PPM_DBUF_MASK;
    assign ref_dbuf_mask = `REF_DBUF_MASK;

    always @(posedge clk) begin
        if (rst) begin
            sclk_s_r <= 3'h0;
            sdata_s_r <= 2'h0;
            le_s_r <= 3'h0;
            dl_s_r <= 2'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], sclk};
            sdata_s_r <= {sdata_s_r[0], sdata};
            le_s_r <= {le_s_r[1:0], load_strobe};
            dl_s_r <= {dl_s_r[0], digital_lock_in};
        end
    end

    // Shifting and latching keep working while asleep.
    always @* begin
        shift_nxt = shift_r;
        if (sclk_rise) begin
            shift_nxt = {shift_r[W-2:0], sdata_s_r[1]}; // RL1
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            shift_r <= `WORD_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // A staged word keeps its whole copy, but only the marked fields are taken from it later.
    // Unmarked bits such as sleep and the staging enable act at once, so they never lag a write.
    always @* begin
        freq_nxt = frequency_word;
        ppm_nxt = prescale_phase_modulus;
        refloop_nxt = reference_and_loop_control;
        clkdiv_nxt = clock_divider_control;
        outstg_nxt = output_stage_control;
        lockctl_nxt = lock_pin_control;
        stage_ppm_nxt = stage_ppm_r;
        stage_ref_nxt = stage_ref_r;
        stage_div_nxt = stage_div_r;
        if (le_rise) begin
            case (sel) // RL2
                `SEL_FREQ: begin
                    freq_nxt = shift_r;
                    ppm_nxt = (prescale_phase_modulus & ~ppm_dbuf_mask) | (stage_ppm_r & ppm_dbuf_mask); // RL4
                    refloop_nxt = (reference_and_loop_control & ~ref_dbuf_mask)
                        | (stage_ref_r & ref_dbuf_mask); // RL4
                    outstg_nxt[`OUTDIV_HI:`OUTDIV_LO] = stage_div_r; // RL5
                end
                `SEL_PPM: begin
                    stage_ppm_nxt = shift_r; // RL4
                    ppm_nxt = (prescale_phase_modulus & ppm_dbuf_mask) | (shift_r & ~ppm_dbuf_mask); // RL4
                end
                `SEL_REFLOOP: begin
                    stage_ref_nxt = shift_r; // RL4
                    refloop_nxt = (reference_and_loop_control & ref_dbuf_mask) | (shift_r & ~ref_dbuf_mask); // RL4
                end
                `SEL_CLKDIV: begin
                    clkdiv_nxt = shift_r;
                end
                `SEL_OUTSTG: begin
                    stage_div_nxt = shift_r[`OUTDIV_HI:`OUTDIV_LO];
                    if (dbuf_en) begin
                        outstg_nxt = {shift_r[W-1:`OUTDIV_HI+1],
                            output_stage_control[`OUTDIV_HI:`OUTDIV_LO], shift_r[`OUTDIV_LO-1:0]}; // RL5
                    end else begin
                        outstg_nxt = shift_r; // RL5
                    end
                end
                `SEL_LOCKPIN: begin
                    lockctl_nxt = shift_r;
                end
                default: begin
                    freq_nxt = frequency_word;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            frequency_word <= `WORD_RESET;
            prescale_phase_modulus <= `WORD_RESET;
            reference_and_loop_control <= `WORD_RESET;
            clock_divider_control <= `WORD_RESET;
            output_stage_control <= `WORD_RESET;
            lock_pin_control <= `WORD_RESET;
            stage_ppm_r <= `WORD_RESET;
            stage_ref_r <= `WORD_RESET;
            stage_div_r <= 3'h0;
        end else begin
            frequency_word <= freq_nxt;
            prescale_phase_modulus <= ppm_nxt;
            reference_and_loop_control <= refloop_nxt;
            clock_divider_control <= clkdiv_nxt;
            output_stage_control <= outstg_nxt;
            lock_pin_control <= lockctl_nxt;
            stage_ppm_r <= stage_ppm_nxt;
            stage_ref_r <= stage_ref_nxt;
            stage_div_r <= stage_div_nxt;
        end
    end

    // Sleep, divider fields and the lock pin are registered from the live words.
    // In sleep the digital lock indication is held off, as its detector is reset.
    always @* begin
        whole_nxt = frequency_word[`WHOLE_HI:`WHOLE_LO]; // RL3
        numer_nxt = frequency_word[`NUMER_HI:`NUMER_LO]; // RL3
        sleep_nxt = reference_and_loop_control[`SLEEP_BIT]; // RL8
        case (lock_pin_control[`LOCKSEL_HI:`LOCKSEL_LO]) // RL6
            `LOCK_DIGITAL: lock_nxt = dl_s_r[1] & ~sleep_nxt; // RL8
            `LOCK_HIGH: lock_nxt = 1'b1;
            default: lock_nxt = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            whole_divider <= 16'h0000;
            partial_numerator <= 12'h000;
            sleep_request <= 1'b0;
            lock_pin <= 1'b0;
        end else begin
            whole_divider <= whole_nxt;
            partial_numerator <= numer_nxt;
            sleep_request <= sleep_nxt;
            lock_pin <= lock_nxt;
        end
    end
endmodule // synth_serial_config_regs
`default_nettype wire

//--- sim/host_serial_model.sv
// Host that shifts words into the bank over the three-wire link.
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
    output logic sclk = 1'h0,
    output logic sdata = 1'h0,
    output logic load_strobe = 1'h0
);
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            sdata = w[i];
            #40 sclk = 1'h1;
            #80 sclk = 1'h0;
            #40;
        end
        sdata = ~sdata;
        #40 load_strobe = 1'h1;
        #80 load_strobe = 1'h0;
        #40;
    endtask
endmodule // host_serial_model
`default_nettype wire

//--- sim/synth_cfg_asserts.sv
// Port assertions for the configuration bank.
`timescale 1ns/1ns
`default_nettype none
module synth_cfg_asserts (
    input wire clk,
    input wire rst,
    input wire sleep_request,
    input wire lock_pin,
    input wire [31:0] frequency_word,
    input wire [31:0] prescale_phase_modulus,
    input wire [31:0] lock_pin_control,
    input wire [15:0] whole_divider,
    input wire [11:0] partial_numerator
);
    wire [1:0] m = lock_pin_control[23:22];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_fld; {whole_divider, partial_numerator} == $past(frequency_word[30:3]); endproperty
    a_fld: assert property (p_fld) else $error("bad field");
    property p_sel; frequency_word[2:0] == 3'h0 && (~|lock_pin_control || lock_pin_control[2:0] == 3'h5); endproperty
    a_sel: assert property (p_sel) else $error("bad select");
    property p_stg; $changed(prescale_phase_modulus[26:3]) |-> $changed(frequency_word); endproperty
    a_stg: assert property (p_stg) else $error("early apply");
    property p_hi; m == 2'h3 && $stable(m) |-> lock_pin; endproperty
    a_hi: assert property (p_hi) else $error("lock not high");
    property p_lo; !m[0] && $stable(m) |-> !lock_pin; endproperty
    a_lo: assert property (p_lo) else $error("lock not low");
    property p_slk; m == 2'h1 && $stable(m) && sleep_request && $past(sleep_request) |-> !lock_pin; endproperty
    a_slk: assert property (p_slk) else $error("lock in sleep");
endmodule // synth_cfg_asserts
bind synth_serial_config_regs synth_cfg_asserts u_chk (.*);
`default_nettype wire

//--- sim/tb_synth_serial_config_regs.sv
// Bench for the configuration bank.
`timescale 1ns/1ns
`default_nettype none
module tb_synth_serial_config_regs;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic dlock = 1'h0;
    wire sclk, sdata, load_strobe, lck, slp;
    wire [31:0] fw, ppm, rlc, cdc, osc, lpc;
    wire [15:0] whl;
    wire [11:0] num;
    int num_errors = 0, cmp_count = 0, cycles = 0;
    synth_serial_config_regs dut (.clk(clk), .rst(rst), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
        .digital_lock_in(dlock), .frequency_word(fw), .prescale_phase_modulus(ppm),
        .reference_and_loop_control(rlc), .clock_divider_control(cdc), .output_stage_control(osc),
        .lock_pin_control(lpc), .whole_divider(whl), .partial_numerator(num), .sleep_request(slp), .lock_pin(lck));
    host_serial_model host (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        num_errors += (g !== e);
        if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
    endtask
    task automatic finish_test(input int extra);
        num_errors += extra;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (++cycles == 30000) finish_test(1);
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'h0;
        host.send(32'h0000_0F09);
        chk("ppm", 32'h0000_0001, ppm);
        host.send(32'h0050_0004);
        chk("osc", 32'h0050_0004, osc);
        host.send(32'h0000_8003);
        chk("cdc", 32'h0000_8003, cdc);
        host.send(32'h0000_0008);
        chk("ppm", 32'h0000_0F09, ppm);
        host.send(32'h0380_2022);
        chk("rlc", 32'h0000_2022, rlc);
        chk("slp", 32'h0000_0001, slp);
        host.send(32'h0000_0010);
        chk("rlc", 32'h0380_2022, rlc);
        host.send(32'h0020_0004);
        chk("osc", 32'h0050_0004, osc);
        host.send(32'h091A_55E0);
        chk("osc", 32'h0020_0004, osc);
        chk("fw", 32'h091A_55E0, fw);
        chk("whl", 32'h0000_1234, whl);
        chk("num", 32'h0000_0ABC, num);
        // Sleep is active here, so digital lock mode must read low although the loop reports lock.
        dlock = 1'h1;
        for (int m = 0; m < 4; m++) begin
            host.send({8'h00, m[1:0], 3'h3, 16'h0000, 3'h5});
            chk("lock", m == 3, lck);
        end
        host.send(32'h0380_2002);
        chk("slp", 32'h0000_0000, slp);
        host.send(32'h0058_0005);
        chk("lock", 32'h0000_0001, lck);
        dlock = 1'h0;
        repeat (6) @(negedge clk);
        chk("lock", 32'h0000_0000, lck);
        host.send(32'h0000_0006);
        chk("lpc", 32'h0058_0005, lpc);
        finish_test(0);
    end
endmodule // tb_synth_serial_config_regs
`default_nettype wire
